// *** logic/smr_ctrl.sv ***
`timescale 1ns/1ps
module smr_ctrl (
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	smr_link_if.ctl LINK,
	input wire logic [4:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	output logic IRQ
);
	import smr_pkg::*;

	logic ack_r; // One wait cycle per access
	logic [31:0] rdata_r;
	logic [17:0] mr2_r; // Staged values
	logic [17:0] mr3_r;
	logic [17:0] sent2_r; // Values last sent to the device
	logic [17:0] sent3_r;
	logic [31:0] cfg_r;
	logic [2:0] ist_r; // Sticky interrupt status
	logic [2:0] ien_r;
	logic crc_d_r; // Previous device error level
	smr_cstate_e state_r;
	logic [5:0] cnt_r;
	logic [3:0] beat_r;
	logic [7:0] acc_r;
	logic mrs_r;
	logic [2:0] sel_r;
	logic [17:0] addr_r;
	logic sync_r;
	logic wr_r;
	logic [7:0] data_r;

	// Bus decode
	wire logic req = AVS_READ | AVS_WRITE;
	wire logic wtake = AVS_WRITE & ack_r;
	wire logic w_cmd = wtake & (AVS_ADDRESS == OFS_CMD);
	wire logic [4:0] cmd = AVS_WRITEDATA[4:0];
	wire logic idle = state_r == C_IDLE;
	wire logic gear_set = sent3_r[MR3_GEAR_BIT];
	// Sync while staying 1N is refused
	wire logic bad_sync = cmd[CMD_SYNC] & ~gear_set;
	wire logic go = w_cmd & idle & (cmd != 5'h00) & ~bad_sync;
	wire logic refuse = w_cmd & (~idle | bad_sync);
	// Command latency forced when CRC and mask both on
	wire logic need_cmdlat = sent2_r[MR2_CRC_BIT] & cfg_r[CFG_DM_BIT];
	wire logic cmdlat_zero = mr3_r[MR3_CMDLAT_LSB +: 2] == 2'h0;
	wire logic [17:0] mr3_out = (need_cmdlat & cmdlat_zero) ?
		((mr3_r & MR3_MASK) | {7'h00, CMDLAT_MIN, 9'h000}) :
		(mr3_r & MR3_MASK);
	wire logic [4:0] wlat = WLAT_TAB[sent2_r[MR2_WLAT_LSB +: 3]];
	wire logic [4:0] al = cfg_r[CFG_AL_LSB +: 5];
	wire logic [5:0] wl = {1'b0, al} + {1'b0, wlat};
	wire logic [3:0] blen = sent2_r[MR2_CRC_BIT] ? BURST_CRC : BURST_STD;
	wire logic crc_beat = beat_r >= BURST_STD;
	wire logic [7:0] base = cfg_r[CFG_BASE_LSB +: 8];
	wire logic [7:0] beat_val = base + {4'h0, beat_r};
	wire logic [7:0] data_nxt = crc_beat ? acc_r : beat_val;
	wire logic crc_rise = LINK.crc_err & ~crc_d_r;
	wire logic done = (state_r == C_DATA) & (beat_r == blen - 4'h1);
	wire logic [31:0] stat = {28'h0000000, LINK.crc_err, gear_set, 1'b0,
		~idle};
	wire logic [31:0] rmux =
		(AVS_ADDRESS == OFS_MR2) ? {14'h0000, mr2_r} :
		(AVS_ADDRESS == OFS_MR3) ? {14'h0000, mr3_r} :
		(AVS_ADDRESS == OFS_CFG) ? cfg_r :
		(AVS_ADDRESS == OFS_STAT) ? stat :
		(AVS_ADDRESS == OFS_IRQ_ST) ? {29'h00000000, ist_r} :
		(AVS_ADDRESS == OFS_IRQ_EN) ? {29'h00000000, ien_r} :
		32'h00000000; // Unmapped and write-only read zero
	wire logic [2:0] ev = {refuse, crc_rise, done};

	assign AVS_WAITREQUEST = req & ~ack_r;
	assign AVS_READDATA = rdata_r;
	assign IRQ = |(ist_r & ien_r);
	assign LINK.mrs = mrs_r;
	assign LINK.mr_sel = sel_r;
	assign LINK.addr = addr_r;
	assign LINK.dev_sel = cfg_r[CFG_SEL_BIT];
	assign LINK.sync = sync_r;
	assign LINK.wr_cmd = wr_r;
	assign LINK.wr_data = data_r;

	// Bus slave and software registers
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			ack_r <= 1'b0;
			rdata_r <= 32'h00000000;
			mr2_r <= 18'h00000;
			mr3_r <= 18'h00000;
			cfg_r <= 32'h00000000;
			ien_r <= 3'h0;
			ist_r <= 3'h0;
			crc_d_r <= 1'b0;
		end else begin
			ack_r <= req & ~ack_r;
			crc_d_r <= LINK.crc_err;
			if (AVS_READ & ~ack_r) begin
				rdata_r <= rmux;
			end
			if (wtake && AVS_ADDRESS == OFS_MR2) begin
				mr2_r <= AVS_WRITEDATA[17:0];
			end
			if (wtake && AVS_ADDRESS == OFS_MR3) begin
				mr3_r <= AVS_WRITEDATA[17:0];
			end
			if (wtake && AVS_ADDRESS == OFS_CFG) begin
				cfg_r <= AVS_WRITEDATA;
			end
			if (wtake && AVS_ADDRESS == OFS_IRQ_EN) begin
				ien_r <= AVS_WRITEDATA[2:0];
			end
			// Events win over a same-cycle clear
			if (wtake && AVS_ADDRESS == OFS_IRQ_CLR) begin
				ist_r <= (ist_r & ~AVS_WRITEDATA[2:0]) | ev;
			end else begin
				ist_r <= ist_r | ev;
			end
		end
	end

	// Link sequencing: lowest set command bit wins
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			state_r <= C_IDLE;
			mrs_r <= 1'b0;
			sel_r <= 3'h0;
			addr_r <= 18'h00000;
			sync_r <= 1'b0;
			wr_r <= 1'b0;
			data_r <= 8'h00;
			cnt_r <= 6'h00;
			beat_r <= 4'h0;
			acc_r <= 8'h00;
			sent2_r <= 18'h00000;
			sent3_r <= 18'h00000;
		end else begin
			mrs_r <= 1'b0;
			sync_r <= 1'b0;
			wr_r <= 1'b0;
			case (state_r)
				C_IDLE: begin
					beat_r <= 4'h0;
					acc_r <= 8'h00;
					if (go && cmd[CMD_MR2]) begin
						mrs_r <= 1'b1;
						sel_r <= SEL_MR2;
						addr_r <= mr2_r & MR2_MASK;
						sent2_r <= mr2_r & MR2_MASK;
					end else if (go && cmd[CMD_MR3]) begin
						mrs_r <= 1'b1;
						sel_r <= SEL_MR3;
						addr_r <= mr3_out;
						sent3_r <= mr3_out;
					end else if (go && cmd[CMD_CLR]) begin
						mrs_r <= 1'b1;
						sel_r <= SEL_MR5;
						addr_r <= 18'h00000;
					end else if (go && cmd[CMD_SYNC]) begin
						sync_r <= 1'b1;
					end else if (go) begin
						wr_r <= 1'b1;
						cnt_r <= wl;
						state_r <= C_WAIT;
					end
				end
				C_WAIT: begin
					cnt_r <= cnt_r - 6'h01;
					if (cnt_r == 6'h01) begin
						state_r <= C_DATA;
						data_r <= beat_val;
						acc_r <= beat_val;
						beat_r <= 4'h1;
					end
				end
				C_DATA: begin
					beat_r <= beat_r + 4'h1;
					data_r <= data_nxt;
					if (!crc_beat) begin
						acc_r <= acc_r ^ beat_val;
					end
					if (beat_r == blen) begin
						state_r <= C_IDLE;
						data_r <= 8'h00;
					end
				end
				default: begin
					state_r <= C_IDLE;
				end
			endcase
		end
	end
endmodule : smr_ctrl

// *** logic/smr_device.sv ***
`timescale 1ns/1ps
// Contract
// - Ignore register commands with select 111.
// - Controller zeroes reserved address bits.
// - Write termination from bits 11:9; 110/111 reserved.
// - Write leveling uses nominal termination only.
// - Decode write latency table from bits 5:3.
// - First data exactly latency cycles after command.
// - Total write latency is additive plus write.
// - Self-refresh range from bits 7:6.
// - CRC on: ten-beat bursts, last two CRC.
// - Controller sets command latency with CRC+mask.
// - Temperature status refreshed, at most 32 ms old.
// - Per-device masked register commands.
// - Reset 1N; gear-down via command then sync.
// - No command or sync when staying 1N.
// - Write termination applies even without nominal.
// - Sticky CRC error until cleared by command.
module smr_device #(
	parameter logic [23:0] TS_PERIOD = smr_pkg::TS_PERIOD_CYC
) (
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	smr_link_if.dev LINK,
	input wire logic [4:0] AL,
	input wire logic WRITE_LEVEL,
	input wire logic [2:0] NOM_TERM,
	input wire logic [1:0] TEMP_CODE,
	output logic [4:0] WLAT_CYC,
	output logic [2:0] TERM_CODE,
	output logic [1:0] SR_RANGE,
	output logic AUTO_SR,
	output logic CRC_ON,
	output logic [1:0] CMD_LAT,
	output logic PDA_ON,
	output logic GEAR_2N,
	output logic [1:0] MPR_TEMP,
	output logic DATA_EXPECT,
	output logic CRC_ERR
);
	import smr_pkg::*;

	logic [17:0] mr2_r; // Second mode register image
	logic [17:0] mr3_r; // Third mode register image
	logic gear_r; // Half-rate (2N) clocking active
	logic crc_err_r; // Sticky CRC failure
	logic [2:0] term_r; // Applied termination code
	logic [1:0] temp_r; // Reported sensor status
	logic [23:0] ts_cnt_r; // Sensor refresh countdown
	smr_dstate_e state_r;
	smr_dstate_e state_nxt;
	logic [5:0] cnt_r; // Cycles left to first beat
	logic [3:0] beat_r; // Beat index within burst
	logic [7:0] acc_r; // Running xor of data beats

	// Command qualification
	wire logic sel_ok = LINK.mr_sel != SEL_RCW;
	wire logic dev_ok = ~mr3_r[MR3_PDA_BIT] | LINK.dev_sel;
	wire logic take = LINK.mrs & sel_ok & dev_ok;
	wire logic take2 = take & (LINK.mr_sel == SEL_MR2);
	wire logic take3 = take & (LINK.mr_sel == SEL_MR3);
	wire logic take5 = take & (LINK.mr_sel == SEL_MR5);
	wire logic clr_crc = take5 & ~LINK.addr[MR5_CRCERR_BIT];

	// Field decode
	wire logic [2:0] wlat_code = mr2_r[MR2_WLAT_LSB +: 3];
	wire logic [4:0] wlat = WLAT_TAB[wlat_code];
	wire logic [2:0] tw = mr2_r[MR2_TW_LSB +: 3];
	wire logic tw_ok = (tw != TW_OFF) & (tw < TW_RSV);
	wire logic crc_on = mr2_r[MR2_CRC_BIT];
	// Whole-cycle latency only; additive part added on top
	wire logic [5:0] wl = {1'b0, AL} + {1'b0, wlat};
	wire logic [3:0] blen = crc_on ? BURST_CRC : BURST_STD;
	wire logic last = beat_r == blen - 4'h1;
	wire logic crc_beat = beat_r >= BURST_STD;
	wire logic in_data = state_r == D_DATA;
	wire logic bad = in_data & crc_beat & (LINK.wr_data != acc_r);
	// Leveling forces nominal; write value needs no nominal
	wire logic use_tw = in_data & ~WRITE_LEVEL & tw_ok;
	wire logic [2:0] term_nxt = use_tw ? tw : NOM_TERM;

	assign WLAT_CYC = wlat;
	assign TERM_CODE = term_r;
	assign SR_RANGE = mr2_r[MR2_SR_LSB +: 2];
	assign AUTO_SR = &mr2_r[MR2_SR_LSB +: 2];
	assign CRC_ON = crc_on;
	assign CMD_LAT = mr3_r[MR3_CMDLAT_LSB +: 2];
	assign PDA_ON = mr3_r[MR3_PDA_BIT];
	assign GEAR_2N = gear_r;
	assign MPR_TEMP = temp_r;
	assign DATA_EXPECT = in_data;
	assign CRC_ERR = crc_err_r;
	assign LINK.crc_err = crc_err_r;

	// Register images change only on an accepted command
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			mr2_r <= 18'h00000;
			mr3_r <= 18'h00000;
		end else begin
			if (take2) begin
				mr2_r <= LINK.addr & MR2_MASK;
			end
			if (take3) begin
				mr3_r <= LINK.addr & MR3_MASK;
			end
		end
	end

	// Gear-down: armed by command, entered on sync
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			gear_r <= 1'b0;
		end else if (!mr3_r[MR3_GEAR_BIT]) begin
			gear_r <= 1'b0; // Back to 1N when disarmed
		end else if (LINK.sync) begin
			gear_r <= 1'b1;
		end
	end

	// Sticky CRC error; a new error beats a clear
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			crc_err_r <= 1'b0;
		end else if (bad) begin
			crc_err_r <= 1'b1;
		end else if (clr_crc) begin
			crc_err_r <= 1'b0;
		end
	end

	// Termination updated every cycle, no command needed
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			term_r <= 3'h0;
		end else begin
			term_r <= term_nxt;
		end
	end

	// Sensor status refresh once every age limit period
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			ts_cnt_r <= 24'h000000;
			temp_r <= 2'h0;
		end else if (ts_cnt_r == 24'h000000) begin
			ts_cnt_r <= TS_PERIOD - 24'h000001;
			if (mr3_r[MR3_TSS_BIT]) begin
				temp_r <= TEMP_CODE;
			end
		end else begin
			ts_cnt_r <= ts_cnt_r - 24'h000001;
		end
	end

	// Write path sequencing
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			D_IDLE: begin
				// A command arriving mid-burst is not taken
				if (LINK.wr_cmd) begin
					state_nxt = D_WAIT;
				end
			end
			D_WAIT: begin
				if (cnt_r == 6'h01) begin
					state_nxt = D_DATA;
				end
			end
			D_DATA: begin
				if (last) begin
					state_nxt = D_IDLE;
				end
			end
			default: begin
				state_nxt = D_IDLE;
			end
		endcase
	end

	// Counters and checksum accumulator
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			state_r <= D_IDLE;
			cnt_r <= 6'h00;
			beat_r <= 4'h0;
			acc_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			if (state_r == D_IDLE) begin
				// Command edge itself is the first latency cycle
				cnt_r <= wl - 6'h01;
				beat_r <= 4'h0;
				acc_r <= 8'h00;
			end else if (state_r == D_WAIT) begin
				cnt_r <= cnt_r - 6'h01;
			end else begin
				beat_r <= beat_r + 4'h1;
				if (!crc_beat) begin
					acc_r <= acc_r ^ LINK.wr_data;
				end
			end
		end
	end
endmodule : smr_device

// *** logic/smr_link_if.sv ***
`timescale 1ns/1ps
interface smr_link_if;
	logic mrs; // Mode register command pulse
	logic [2:0] mr_sel; // Register select
	logic [17:0] addr; // Register value
	logic dev_sel; // Per-device select for masked commands
	logic sync; // Gear-down sync pulse
	logic wr_cmd; // Internal write command pulse
	logic [7:0] wr_data; // Write beat data
	logic crc_err; // Sticky write CRC error from device
	modport dev(input mrs, mr_sel, addr, dev_sel, sync, wr_cmd, wr_data,
		output crc_err);
	modport ctl(output mrs, mr_sel, addr, dev_sel, sync, wr_cmd, wr_data,
		input crc_err);
endinterface : smr_link_if

// *** logic/smr_pkg.sv ***
package smr_pkg;
	// Mode register select codes (BG0, BA1, BA0)
	localparam logic [2:0] SEL_MR2 = 3'h2;
	localparam logic [2:0] SEL_MR3 = 3'h3;
	localparam logic [2:0] SEL_MR5 = 3'h5;
	localparam logic [2:0] SEL_RCW = 3'h7; // Register control words
	// Second mode register fields
	localparam int MR2_WLAT_LSB = 3;
	localparam int MR2_SR_LSB = 6;
	localparam int MR2_TW_LSB = 9;
	localparam int MR2_CRC_BIT = 12;
	localparam logic [17:0] MR2_MASK = 18'h01EF8; // Defined bits only
	// Third mode register fields
	localparam int MR3_GEAR_BIT = 3;
	localparam int MR3_PDA_BIT = 4;
	localparam int MR3_TSS_BIT = 5;
	localparam int MR3_CMDLAT_LSB = 9;
	localparam logic [17:0] MR3_MASK = 18'h00638;
	localparam logic [1:0] CMDLAT_MIN = 2'h1; // Least nonzero latency code
	// Fifth register: write CRC error status bit
	localparam int MR5_CRCERR_BIT = 3;
	// Termination codes at or above this are reserved
	localparam logic [2:0] TW_RSV = 3'h6;
	localparam logic [2:0] TW_OFF = 3'h0;
	// Write latency decode, in clock cycles
	localparam logic [4:0] WLAT_TAB [8] = '{5'h09, 5'h0A, 5'h0B, 5'h0C,
		5'h0E, 5'h10, 5'h12, 5'h14};
	// Burst lengths in unit intervals
	localparam logic [3:0] BURST_STD = 4'h8;
	localparam logic [3:0] BURST_CRC = 4'hA;
	// Temperature status age limit
	localparam int TS_AGE_MS = 32;
	localparam int CLK_MHZ = 100;
	localparam logic [23:0] TS_PERIOD_CYC = 24'(TS_AGE_MS * 1000 * CLK_MHZ);
	// Controller register byte offsets
	localparam logic [4:0] OFS_MR2 = 5'h00;
	localparam logic [4:0] OFS_MR3 = 5'h04;
	localparam logic [4:0] OFS_CMD = 5'h08;
	localparam logic [4:0] OFS_CFG = 5'h0C;
	localparam logic [4:0] OFS_STAT = 5'h10;
	localparam logic [4:0] OFS_IRQ_ST = 5'h14;
	localparam logic [4:0] OFS_IRQ_CLR = 5'h18;
	localparam logic [4:0] OFS_IRQ_EN = 5'h1C;
	// Command bits
	localparam int CMD_MR2 = 0;
	localparam int CMD_MR3 = 1;
	localparam int CMD_CLR = 2;
	localparam int CMD_SYNC = 3;
	localparam int CMD_WR = 4;
	// Configuration fields
	localparam int CFG_AL_LSB = 0;
	localparam int CFG_DM_BIT = 8;
	localparam int CFG_SEL_BIT = 9;
	localparam int CFG_BASE_LSB = 16;
	// Interrupt bits
	localparam int IRQ_DONE = 0;
	localparam int IRQ_CRC = 1;
	localparam int IRQ_REFUSE = 2;
	// State encodings
	typedef enum logic [2:0] {
		D_IDLE = 3'b001,
		D_WAIT = 3'b010,
		D_DATA = 3'b100
	} smr_dstate_e;
	typedef enum logic [2:0] {
		C_IDLE = 3'b001,
		C_WAIT = 3'b010,
		C_DATA = 3'b100
	} smr_cstate_e;
endpackage : smr_pkg

// *** tb/smr_link_chk.sv ***
`timescale 1ns/1ps
// Watches the link between the controller and the device
module smr_link_chk (
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	input wire logic mrs,
	input wire logic [2:0] mr_sel,
	input wire logic [17:0] addr,
	input wire logic dev_sel,
	input wire logic sync,
	input wire logic wr_cmd,
	input wire logic [7:0] wr_data,
	input wire logic crc_err
);
	import smr_pkg::*;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);
	// One command per pulse, so images move only once
	a_mrs_pulse: assert property (mrs |=> !mrs)
		else $error("mode command held past one cycle");
	a_mr2_zeros: assert property (
		mrs && mr_sel == SEL_MR2 |-> (addr & ~MR2_MASK) == 18'h0)
		else $error("undefined bit set in second register value");
	a_mr3_zeros: assert property (
		mrs && mr_sel == SEL_MR3 |-> (addr & ~MR3_MASK) == 18'h0)
		else $error("undefined bit set in third register value");
	a_no_rcw: assert property (mrs |-> mr_sel != SEL_RCW)
		else $error("controller sent the control word select");
	// Sync stands alone and lasts one cycle
	a_sync_alone: assert property (sync |-> !mrs ##1 !sync)
		else $error("sync overlapped a command or stretched");
	// Controller stays busy for at least one standard burst length
	a_wr_spacing: assert property (wr_cmd |=> !wr_cmd [*8])
		else $error("write commands too close");
	a_crc_sticky: assert property (crc_err && !mrs |=> crc_err)
		else $error("error flag dropped without a command");
	a_crc_clear: assert property (
		mrs && mr_sel == SEL_MR5 && !addr[MR5_CRCERR_BIT] |=> !crc_err)
		else $error("error flag survived its clear");
	c_mr2: cover property (mrs && mr_sel == SEL_MR2);
	c_mr3: cover property (mrs && mr_sel == SEL_MR3);
	c_sync: cover property (sync);
	c_write: cover property (wr_cmd);
endmodule : smr_link_chk

// *** tb/tb_sdram_mode_reg2_reg3_config.sv ***
`timescale 1ns/1ps
module tb_sdram_mode_reg2_reg3_config;
	import smr_pkg::*;
	// Row: second register value, latency, refresh range
	typedef struct packed {
		logic [17:0] mr2;
		logic [4:0] wlat;
		logic [1:0] sr;
	} smr_row_s;
	localparam smr_row_s ROWS [8] = '{
		'{18'h00200, 5'h09, 2'h0}, '{18'h00448, 5'h0A, 2'h1},
		'{18'h00690, 5'h0B, 2'h2}, '{18'h008D8, 5'h0C, 2'h3},
		'{18'h00A20, 5'h0E, 2'h0}, '{18'h00C68, 5'h10, 2'h1},
		'{18'h00EB0, 5'h12, 2'h2}, '{18'h010F8, 5'h14, 2'h3}};
	localparam logic [4:0] AL_SET = 5'h03; // Additive latency
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [4:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [31:0] avs_readdata, rd;
	logic avs_waitrequest, irq;
	logic write_level = 1'b0;
	logic [2:0] nom_term = 3'h0;
	logic [1:0] temp_code = 2'h0;
	logic [4:0] wlat_cyc, wlat2;
	logic [2:0] term_code;
	logic [1:0] sr_range, cmd_lat, mpr_temp;
	logic auto_sr, crc_on, pda2, gear_2n, data_expect, crc2;
	int failures = 0;
	int check_count = 0;
	int n;
	smr_link_if link ();
	smr_link_if link2 (); // Second device, driven by the bench
	smr_ctrl smr_ctrl_i (.CLK_SYS(clk_sys), .RESET_N(reset_n),
		.LINK(link.ctl), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
		.AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
		.AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
		.IRQ(irq));
	// Short sensor period keeps the refresh test brief
	smr_device #(.TS_PERIOD(24'h10)) smr_device_i (.CLK_SYS(clk_sys),
		.RESET_N(reset_n), .LINK(link.dev), .AL(AL_SET),
		.WRITE_LEVEL(write_level), .NOM_TERM(nom_term),
		.TEMP_CODE(temp_code), .WLAT_CYC(wlat_cyc), .TERM_CODE(term_code),
		.SR_RANGE(sr_range), .AUTO_SR(auto_sr), .CRC_ON(crc_on),
		.CMD_LAT(cmd_lat),
		.PDA_ON(), .GEAR_2N(gear_2n), .MPR_TEMP(mpr_temp),
		.DATA_EXPECT(data_expect), .CRC_ERR());
	smr_device #(.TS_PERIOD(24'h10)) smr_device_i2 (.CLK_SYS(clk_sys),
		.RESET_N(reset_n), .LINK(link2.dev), .AL(AL_SET),
		.WRITE_LEVEL(write_level), .NOM_TERM(nom_term),
		.TEMP_CODE(temp_code), .WLAT_CYC(wlat2), .TERM_CODE(), .SR_RANGE(),
		.AUTO_SR(), .CRC_ON(), .CMD_LAT(), .PDA_ON(pda2), .GEAR_2N(),
		.MPR_TEMP(), .DATA_EXPECT(), .CRC_ERR(crc2));
	smr_link_chk smr_link_chk_i (.CLK_SYS(clk_sys), .RESET_N(reset_n),
		.mrs(link.mrs), .mr_sel(link.mr_sel), .addr(link.addr),
		.dev_sel(link.dev_sel), .sync(link.sync), .wr_cmd(link.wr_cmd),
		.wr_data(link.wr_data), .crc_err(link.crc_err));
	// Free-running clock
	always #5 clk_sys = ~clk_sys;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// One bus access; held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	// Write burst through the controller; times latency and beats
	task automatic burst(input int len, input int wl, input logic [2:0] t);
		bus(1'b1, OFS_CMD, 32'h10);
		do @(negedge clk_sys); while (link.wr_cmd !== 1'b1);
		n = 0;
		while (data_expect !== 1'b1 && n < 64) begin
			@(negedge clk_sys);
			n++;
		end
		check(n, wl);
		n = 0;
		while (data_expect === 1'b1) begin
			@(negedge clk_sys);
			n++;
		end
		check(n, len);
		check(term_code, t);
		// Back on a rising edge, so later inputs change there
		@(posedge clk_sys);
	endtask : burst
	// Raw command on the second link
	task automatic mrs2(input logic [2:0] s, input logic [17:0] a,
		input logic ds);
		@(posedge clk_sys);
		link2.mrs <= 1'b1;
		link2.mr_sel <= s;
		link2.addr <= a;
		link2.dev_sel <= ds;
		@(posedge clk_sys);
		link2.mrs <= 1'b0;
		@(posedge clk_sys);
	endtask : mrs2
	task automatic stop_test();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	// Watchdog, far beyond the expected run
	initial begin
		#200000;
		failures++;
		stop_test();
	end
	// Main sequence
	initial begin
		{link2.mrs, link2.mr_sel, link2.addr, link2.dev_sel} = '0;
		{link2.sync, link2.wr_cmd, link2.wr_data} = '0;
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		check(wlat_cyc, 5'h09);
		check(gear_2n, 1'b0);
		bus(1'b1, OFS_CFG, 32'(AL_SET));
		// Sync before the gear bit is refused and flagged
		bus(1'b1, OFS_IRQ_EN, 32'h7);
		bus(1'b1, OFS_CMD, 32'h8);
		bus(1'b0, OFS_IRQ_ST, 32'h0);
		check(rd[IRQ_REFUSE], 1'b1);
		check(irq, 1'b1);
		check(gear_2n, 1'b0);
		bus(1'b1, OFS_IRQ_CLR, 32'h4);
		// Clear lands at the accepting edge; look one cycle later
		@(posedge clk_sys);
		check(irq, 1'b0);
		bus(1'b0, 5'h02, 32'h0);
		check(rd, 32'h0);
		foreach (ROWS[i]) begin
			bus(1'b1, OFS_MR2, 32'(ROWS[i].mr2));
			bus(1'b1, OFS_CMD, 32'h1);
			repeat (3) @(posedge clk_sys);
			check(wlat_cyc, ROWS[i].wlat);
			check(sr_range, ROWS[i].sr);
			check(auto_sr, ROWS[i].sr == 2'h3);
			check(crc_on, ROWS[i].mr2[MR2_CRC_BIT]);
			bus(1'b0, OFS_MR2, 32'h0);
			check(rd, 32'(ROWS[i].mr2));
		end
		// Bursts: termination without nominal, leveling, reserved code
		bus(1'b1, OFS_IRQ_EN, 32'h0);
		bus(1'b1, OFS_MR2, 32'h200);
		bus(1'b1, OFS_CMD, 32'h1);
		burst(8, 12, 3'h1);
		write_level <= 1'b1;
		nom_term <= 3'h2;
		burst(8, 12, 3'h2);
		write_level <= 1'b0;
		bus(1'b1, OFS_MR2, 32'h1C38);
		bus(1'b1, OFS_CMD, 32'h1);
		burst(10, 23, 3'h2);
		check(link.crc_err, 1'b0);
		bus(1'b0, OFS_IRQ_ST, 32'h0);
		check(rd[IRQ_DONE], 1'b1);
		check(irq, 1'b0);
		// Third register: latency fix-up, gear-down, sensor status
		bus(1'b1, OFS_CFG, 32'h103);
		bus(1'b1, OFS_MR3, 32'h28);
		bus(1'b1, OFS_CMD, 32'h2);
		bus(1'b1, OFS_CMD, 32'h8);
		repeat (3) @(posedge clk_sys);
		check(cmd_lat, CMDLAT_MIN);
		check(gear_2n, 1'b1);
		check(wlat_cyc, 5'h14);
		// Status: gear bit sent, idle, no error
		bus(1'b0, OFS_STAT, 32'h0);
		check(rd, 32'h4);
		temp_code <= 2'h2;
		repeat (20) @(posedge clk_sys);
		check(mpr_temp, 2'h2);
		// Second device: ignored selects, masking, sticky error
		mrs2(SEL_MR2, 18'h00008, 1'b1);
		check(wlat2, 5'h0A);
		mrs2(SEL_RCW, 18'h00038, 1'b1);
		check(wlat2, 5'h0A);
		mrs2(SEL_MR3, 18'h00010, 1'b1);
		check(pda2, 1'b1);
		mrs2(SEL_MR2, 18'h00010, 1'b0);
		check(wlat2, 5'h0A);
		mrs2(SEL_MR2, 18'h01000, 1'b1);
		check(wlat2, 5'h09);
		@(posedge clk_sys);
		link2.wr_cmd <= 1'b1;
		@(posedge clk_sys);
		link2.wr_cmd <= 1'b0;
		repeat (11) @(posedge clk_sys);
		// Beats 0..7 xor to zero, so a nonzero check beat is wrong
		for (int k = 0; k < 10; k++) begin
			link2.wr_data <= (k < 8) ? 8'(k) : 8'h5A;
			@(posedge clk_sys);
		end
		link2.wr_data <= 8'h00;
		repeat (3) @(posedge clk_sys);
		check(crc2, 1'b1);
		mrs2(SEL_MR2, 18'h01000, 1'b1);
		check(crc2, 1'b1);
		mrs2(SEL_MR5, 18'h00000, 1'b1);
		check(crc2, 1'b0);
		// Clear goes out when idle; a command while busy is refused
		bus(1'b1, OFS_CMD, 32'h4);
		check(link.crc_err, 1'b0);
		bus(1'b1, OFS_IRQ_CLR, 32'h7);
		bus(1'b1, OFS_CMD, 32'h10);
		bus(1'b1, OFS_CMD, 32'h1);
		bus(1'b0, OFS_IRQ_ST, 32'h0);
		check(rd[IRQ_REFUSE], 1'b1);
		check(rd[IRQ_DONE], 1'b0);
		// Reset during the write latency wait returns both ends to their defaults
		@(posedge clk_sys);
		reset_n <= 1'b0;
		@(posedge clk_sys);
		check(gear_2n, 1'b0);
		check(wlat_cyc, 5'h09);
		check(link.wr_data, 8'h00);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		check(data_expect, 1'b0);
		stop_test();
	end
endmodule : tb_sdram_mode_reg2_reg3_config
